// file: src/sram_host_pkg.sv
/*
 * Constants for the host-side controller of a 4096 x 1 static memory
 * with chip-enable and write strobes and separate data in/out pins.
 * Assumes a 100 MHz controller clock; times are for the slowest grade.
 */
package sram_host_pkg;

    // ------------------------------------------------------------------
    // Clock and organisation
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_BITS     = 12;
    localparam int WORDS         = 4096;
    localparam int SYNC_STAGES   = 2;
    localparam int TIMER_BITS    = 8;

    // ------------------------------------------------------------------
    // Memory timing, ns
    // ------------------------------------------------------------------
    localparam int CYCLE_PERIOD_NS          = 235;
    localparam int READ_LATENCY_NS          = 150;
    localparam int CE_LOW_NS                = 150;
    localparam int CE_HIGH_NS               = 75;
    localparam int WRITE_PULSE_WIDTH_NS     = 90;
    localparam int DATA_SETUP_NS            = 90;
    localparam int OUTPUT_RELEASE_AFTER_WRITE_NS    = 40;
    localparam int OUTPUT_RELEASE_AFTER_DESELECT_NS = 60;

    // ------------------------------------------------------------------
    // Derived cycle counts: least times round up, longest times round up
    // too here, since the host must wait them out
    // ------------------------------------------------------------------
    localparam int CYCLE_PERIOD_CYC =
        (CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_LATENCY_CYC =
        (READ_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CE_LOW_CYC =
        (CE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CE_HIGH_CYC =
        (CE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC =
        (WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_SETUP_CYC =
        (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_W_CYC =
        (OUTPUT_RELEASE_AFTER_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_D_CYC =
        (OUTPUT_RELEASE_AFTER_DESELECT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    localparam int READ_LOW_RAW = READ_LATENCY_CYC + SYNC_STAGES;
    localparam int READ_LOW_CYC =
        (READ_LOW_RAW > CE_LOW_CYC) ? READ_LOW_RAW : CE_LOW_CYC;
    localparam int WR_DATA_CYC =
        (WRITE_PULSE_CYC > DATA_SETUP_CYC) ? WRITE_PULSE_CYC
                                           : DATA_SETUP_CYC;
    localparam int WRITE_LOW_RAW = RELEASE_W_CYC + WR_DATA_CYC;
    localparam int WRITE_LOW_CYC =
        (WRITE_LOW_RAW > CE_LOW_CYC) ? WRITE_LOW_RAW : CE_LOW_CYC;

    // ------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_READ,
        ST_WRITE,
        ST_WEND,
        ST_RECOVER
    } ctrl_state_t;

endpackage

// file: src/phase_timer_if.sv
/*
 * Carrier between the controller and its phase timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface phase_timer_if;
    import sram_host_pkg::*;

    logic                  load;
    logic [TIMER_BITS-1:0] load_val;
    logic [TIMER_BITS-1:0] count;
    logic                  done;

    modport ctrl  (output load, output load_val, input count, input done);
    modport timer (input load, input load_val, output count, output done);
endinterface

// file: src/phase_timer.sv
/*
 * Down counter that times each strobe phase.
 * Assumes load comes from logic on the same clock; done is high when
 * the count has reached zero.
 */
`timescale 1ns/1ps
module phase_timer
    import sram_host_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Control
    phase_timer_if.timer tmr
);

    logic [TIMER_BITS-1:0] cnt;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= '0;
        end else if (tmr.load) begin
            cnt <= tmr.load_val;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign tmr.count = cnt;
    assign tmr.done  = (cnt == '0);

endmodule // phase_timer

// file: src/sram_host_ctrl.sv
/*
 * Host controller for a 4096 x 1 static memory driven through its
 * chip-enable, write-enable, address and data pins.
 * Assumes the memory pins are asynchronous to ref_clk, so the data
 * output pin is synchronised before use.
 */
`timescale 1ns/1ps
module sram_host_ctrl
    import sram_host_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS
)
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    // User request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              req_wdata,
    // User answer
    output logic                   rsp_valid,
    output logic                   rsp_rdata,
    // Memory pins
    output logic                   mem_ce_n,
    output logic                   mem_we_n,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_din,
    output logic                   mem_din_oe,
    input  wire logic              mem_dout
);

    // ------------------------------------------------------------------
    // State and timers
    // ------------------------------------------------------------------
    ctrl_state_t           state;
    ctrl_state_t           next_state;
    logic                  pending_write;
    logic [TIMER_BITS-1:0] since_fall;
    logic [SYNC_STAGES-1:0] dout_sync;

    phase_timer_if tmr ();

    phase_timer u_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tmr     (tmr.timer)
    );

    assign req_ready = (state == ST_IDLE);

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state   = state;
        tmr.load     = 1'b0;
        tmr.load_val = '0;
        case (state)
            ST_IDLE: begin
                // Strobes may rest here indefinitely
                if (req_valid) begin
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Address already stable; wait out the cycle period
                if (since_fall >= TIMER_BITS'(CYCLE_PERIOD_CYC)) begin
                    tmr.load = 1'b1;
                    if (pending_write) begin
                        next_state   = ST_WRITE;
                        tmr.load_val = TIMER_BITS'(WRITE_LOW_CYC - 1);
                    end else begin
                        next_state   = ST_READ;
                        tmr.load_val = TIMER_BITS'(READ_LOW_CYC - 1);
                    end
                end
            end
            ST_READ: begin
                if (tmr.done) begin
                    next_state   = ST_RECOVER;
                    tmr.load     = 1'b1;
                    tmr.load_val = TIMER_BITS'(CE_HIGH_CYC - 1);
                end
            end
            ST_WRITE: begin
                if (tmr.done) begin
                    next_state = ST_WEND;
                end
            end
            ST_WEND: begin
                next_state   = ST_RECOVER;
                tmr.load     = 1'b1;
                tmr.load_val = TIMER_BITS'(CE_HIGH_CYC - 1);
            end
            ST_RECOVER: begin
                if (tmr.done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Time since the last chip-enable fall, saturating
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            since_fall <= TIMER_BITS'(CYCLE_PERIOD_CYC);
        end else if (state == ST_SETUP && next_state != ST_SETUP) begin
            since_fall <= TIMER_BITS'(1);
        end else if (since_fall < TIMER_BITS'(CYCLE_PERIOD_CYC)) begin
            since_fall <= since_fall + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Request capture: address and data held for the whole cycle
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_addr      <= '0;
            mem_din       <= 1'b0;
            pending_write <= 1'b0;
        end else if (state == ST_IDLE && req_valid) begin
            mem_addr      <= req_addr;
            mem_din       <= req_wdata;
            pending_write <= req_write;
        end
    end

    // ------------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_ce_n <= 1'b1;
            mem_we_n <= 1'b1;
        end else begin
            // Chip enable low only through the access phases
            mem_ce_n <= !(next_state == ST_READ ||
                          next_state == ST_WRITE ||
                          next_state == ST_WEND);
            // Write strobe falls with chip enable, rises one cycle
            // before it so the write strobe ends the write
            mem_we_n <= (next_state != ST_WRITE);
        end
    end

    // ------------------------------------------------------------------
    // Write data drive, delayed until the memory output is released
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_din_oe <= 1'b0;
        end else if (state == ST_WRITE &&
                     tmr.count <= TIMER_BITS'(WRITE_LOW_CYC - 1
                                              - RELEASE_W_CYC)) begin
            mem_din_oe <= 1'b1;
        end else if (state == ST_WEND) begin
            // Hold data across the write strobe's rising edge
            mem_din_oe <= 1'b1;
        end else begin
            mem_din_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data: pin synchronised, sampled at the end of the low phase
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dout_sync <= '0;
        end else begin
            dout_sync <= {dout_sync[SYNC_STAGES-2:0], mem_dout};
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 1'b0;
        end else if (state == ST_READ && tmr.done) begin
            // Sampled before chip enable rises and the output turns off
            rsp_valid <= 1'b1;
            rsp_rdata <= dout_sync[SYNC_STAGES-1];
        end else if (state == ST_WEND) begin
            rsp_valid <= 1'b1;
        end else begin
            rsp_valid <= 1'b0;
        end
    end

endmodule // sram_host_ctrl

// file: tb/sram_host_ctrl_asserts.sv
/*
 * Pin-level checker for the memory host controller.
 * Assumes it is bound onto sram_host_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
module sram_host_ctrl_asserts
    import sram_host_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS
)
(
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              resetn,
    // User side
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire logic              req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic              req_wdata,
    input wire logic              rsp_valid,
    input wire logic              rsp_rdata,
    // Memory pins
    input wire logic              mem_ce_n,
    input wire logic              mem_we_n,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              mem_din,
    input wire logic              mem_din_oe,
    input wire logic              mem_dout
);
    logic [7:0] low_cnt;
    logic [7:0] high_cnt;
    logic [7:0] per_cnt;
    logic [7:0] wlo_cnt;
    logic       take;

    assign take = req_valid && req_ready;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // Phase counters
    // ------------------------------------------------------------------
    // High and period counters start full after reset so the first cycle after reset is legal; low and write-low counters start at zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt  <= 8'h00;
            high_cnt <= 8'hFF;
            per_cnt  <= 8'hFF;
            wlo_cnt  <= 8'h00;
        end else begin
            low_cnt  <= mem_ce_n ? 8'h00 : low_cnt + 8'(low_cnt != 8'hFF);
            high_cnt <= !mem_ce_n ? 8'h00 : high_cnt + 8'(high_cnt != 8'hFF);
            per_cnt  <= $fell(mem_ce_n) ? 8'h01
                                        : per_cnt + 8'(per_cnt != 8'hFF);
            wlo_cnt  <= mem_we_n ? 8'h00 : wlo_cnt + 8'(wlo_cnt != 8'hFF);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence wr_begin;
        $fell(mem_we_n);
    endsequence
    sequence oe_held_off;
        !mem_din_oe [*4];
    endsequence

    take_to_ce_a: assert property (take |-> ##2 $fell(mem_ce_n))
        else $error("chip enable late after take");
    addr_hold_a: assert property (!mem_ce_n |-> $stable(mem_addr))
        else $error("address moved while selected");
    read_strobe_a: assert property (
        take && !req_write |-> ##2 mem_we_n [*8])
        else $error("write strobe low in a read");
    write_strobe_a: assert property (
        take && req_write |-> ##2 (!mem_we_n && $fell(mem_ce_n)))
        else $error("write strobe missing in a write");
    we_in_ce_a: assert property (!mem_we_n |-> !mem_ce_n)
        else $error("write strobe low while deselected");
    ce_low_a: assert property (
        $rose(mem_ce_n) |-> low_cnt >= CE_LOW_CYC)
        else $error("chip enable low too short");
    ce_high_a: assert property ($fell(mem_ce_n) |-> high_cnt >= CE_HIGH_CYC)
        else $error("chip enable high too short");
    cycle_period_a: assert property (
        $fell(mem_ce_n) |-> per_cnt >= CYCLE_PERIOD_CYC)
        else $error("chip enable falls too close");
    we_pulse_a: assert property (
        $rose(mem_we_n) |-> wlo_cnt >= WRITE_PULSE_CYC)
        else $error("write pulse too short");
    din_hold_a: assert property (
        (!mem_we_n || $rose(mem_we_n)) |-> $stable(mem_din))
        else $error("write data moved during write");
    release_wait_a: assert property (wr_begin |-> oe_held_off)
        else $error("data driven before output release");
    rsp_end_a: assert property (rsp_valid |-> $rose(mem_ce_n))
        else $error("answer without end of cycle");
    resp_bound_a: assert property (take |-> ##[17:40] rsp_valid)
        else $error("no answer in time");
    oe_at_end_a: assert property (
        $rose(mem_we_n) |-> mem_din_oe)
        else $error("write data not driven at strobe end");
endmodule // sram_host_ctrl_asserts

bind sram_host_ctrl sram_host_ctrl_asserts #(.ADDR_W(ADDR_W))
    sram_host_ctrl_asserts_inst (.ref_clk, .resetn, .req_valid, .req_ready,
    .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .mem_ce_n,
    .mem_we_n, .mem_addr, .mem_din, .mem_din_oe, .mem_dout);

// file: tb/sram_cell_model.sv
/*
 * Behavioural 4096 x 1 static memory on the controller's far side.
 * Assumes its strobes come from clocked flops of the controller.
 */
`timescale 1ns/1ps
module sram_cell_model
    import sram_host_pkg::*;
(
    // Memory pins
    input  wire logic                 ce_n,
    input  wire logic                 we_n,
    input  wire logic [ADDR_BITS-1:0] addr,
    input  wire logic                 din,
    output logic                      dout
);
    logic cells [WORDS];
    logic last  = 1'b0;
    logic wr_on = 1'b0;

    initial dout = 1'b1;

    // Released output shows garbage, so a late sample reads wrong
    always @(posedge ce_n or negedge we_n) begin
        dout = ~last;
    end

    // One ns inside the limit so a flop at the limit is not a race
    always @(negedge ce_n) begin
        #(READ_LATENCY_NS - 1);
        if (!ce_n && we_n) begin
            dout = cells[addr];
            last = dout;
        end
    end

    always @(ce_n or we_n) begin
        if (!ce_n && !we_n)
            wr_on = 1'b1;
    end

    always @(posedge ce_n or posedge we_n) begin
        if (wr_on)
            cells[addr] = din;
        wr_on = 1'b0;
    end
endmodule // sram_cell_model

// file: tb/static_ram_4k_by_1_access_tb.sv
/*
 * Self-checking bench for the memory host controller.
 * Assumes the behavioural memory model and a 100 MHz clock.
 */
`timescale 1ns/1ps
module static_ram_4k_by_1_access_tb;
    import sram_host_pkg::*;
    logic                 ref_clk   = 1'b0;
    logic                 resetn    = 1'b0;
    logic                 req_valid = 1'b0;
    logic                 req_write = 1'b0;
    logic [ADDR_BITS-1:0] req_addr  = '0;
    logic                 req_wdata = 1'b0;
    logic                 req_ready, rsp_valid, rsp_rdata;
    logic                 mem_ce_n, mem_we_n, mem_din, mem_din_oe;
    logic                 mem_dout;
    logic [ADDR_BITS-1:0] mem_addr;
    int                   bad_count   = 0;
    int                   comparisons = 0;

    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    sram_host_ctrl sram_host_ctrl_inst (.ref_clk, .resetn, .req_valid,
        .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid,
        .rsp_rdata, .mem_ce_n, .mem_we_n, .mem_addr, .mem_din,
        .mem_din_oe, .mem_dout);
    sram_cell_model sram_cell_model_inst (.ce_n(mem_ce_n),
        .we_n(mem_we_n), .addr(mem_addr), .din(mem_din), .dout(mem_dout));

    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One transfer; request held until the take edge
    task automatic access(input logic wr, input logic [11:0] a,
                          input logic d, output logic q);
        int n;
        int lat;
        n = 0;
        lat = wr ? WRITE_LOW_CYC + 3 : READ_LOW_CYC + 2;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr  <= a;
        req_wdata <= d;
        @(negedge ref_clk);
        while (!req_ready && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        req_valid <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check("ce_n", 12'(mem_ce_n), 12'h000);
        check("we_n", 12'(mem_we_n), 12'(!wr));
        check("addr", mem_addr, a);
        if (wr)
            check("din", 12'(mem_din), 12'(d));
        // n counts edges from the take edge, itself included, to the one that raises the answer
        n = 3;
        while (!rsp_valid && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        check("latency", 12'(n), 12'(lat));
        check("din_oe", 12'(mem_din_oe), 12'(wr));
        q = rsp_rdata;
    endtask

    task automatic t_reset;
        check("rst ce_n", 12'(mem_ce_n), 12'h001);
        check("rst we_n", 12'(mem_we_n), 12'h001);
        check("rst oe", 12'(mem_din_oe), 12'h000);
        check("rst rsp", 12'(rsp_valid), 12'h000);
        check("rst ready", 12'(req_ready), 12'h001);
    endtask

    // Corner addresses, both polarities, written then read back
    task automatic t_table;
        logic [11:0] at [6] = '{12'h000, 12'hFFF, 12'h555, 12'hAAA,
                                12'h001, 12'h800};
        logic q;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++)
                access(1'b1, at[i], 1'(p ^ i), q);
            for (int i = 0; i < 6; i++) begin
                access(1'b0, at[i], 1'b0, q);
                check("rdata", 12'(q), 12'(p ^ (i & 1)));
            end
        end
    endtask

    // Long idle and a controller reset must not lose data
    task automatic t_pause;
        logic q;
        repeat (300) @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        access(1'b0, 12'hFFF, 1'b0, q);
        check("kept", 12'(q), 12'h000);
        access(1'b1, 12'hFFF, 1'b1, q);
        access(1'b0, 12'hFFF, 1'b0, q);
        check("rewrite", 12'(q), 12'h001);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        t_reset;
        resetn <= 1'b1;
        t_table;
        t_pause;
        close_out;
    end

    initial begin
        #(20000 * CLK_PERIOD_NS);
        bad_count++;
        close_out;
    end
endmodule // static_ram_4k_by_1_access_tb
